// ==== hdl/icp_pkg.sv ====
// Shared constants and types of the interconnect port service layer
package icp_pkg;
   localparam int unsigned CHAR_W     = 8;
   localparam int unsigned SEND_MAX   = 4;
   localparam int unsigned TXQ_DEPTH  = 16;
   localparam int unsigned RXQ_DEPTH  = 8;
   localparam int unsigned SKID_DEPTH = 2;
   localparam logic [1:0]  NUM_BUF    = 2'h3;
   localparam logic [1:0]  LOCAL_PORT = 2'h0;
   localparam logic [3:0]  CONN_RESET = 4'h0;

   typedef enum logic [2:0] {
      op_listen, op_connect, op_send, op_receive, op_close, op_reset
   } op_t;

   typedef enum logic [2:0] {
      good_resp, inv_port_resp, port_in_use_resp, inv_conn_resp,
      inv_buf_resp, no_room_resp, rcv_pending_resp
   } resp_t;

   typedef enum logic [1:0] {
      ind_connected, ind_received, ind_closed, ind_reset_rcvd
   } ind_t;
endpackage

// ==== hdl/svc_if.sv ====
// Service request, response and indication channel between both ends
`timescale 1ns/1ns
`default_nettype none
interface svc_if;
   import icp_pkg::*;
   logic        req_valid;
   logic        req_ready;
   op_t         req_op;
   logic [1:0]  req_port;
   logic [3:0]  req_conn;
   logic [1:0]  req_buf;
   logic [2:0]  req_len;
   logic [31:0] req_data;
   logic        resp_valid;
   resp_t       resp_code;
   logic [3:0]  resp_conn;
   logic        ind_valid;
   ind_t        ind_kind;
   logic [3:0]  ind_conn;
   logic [1:0]  ind_port;
   logic [1:0]  ind_buf;
   logic [2:0]  ind_count;
   logic [31:0] ind_data;

   modport dev (
      input  req_valid, req_op, req_port, req_conn, req_buf, req_len,
             req_data,
      output req_ready, resp_valid, resp_code, resp_conn, ind_valid,
             ind_kind, ind_conn, ind_port, ind_buf, ind_count, ind_data
   );
   modport xport (
      output req_valid, req_op, req_port, req_conn, req_buf, req_len,
             req_data,
      input  req_ready, resp_valid, resp_code, resp_conn, ind_valid,
             ind_kind, ind_conn, ind_port, ind_buf, ind_count, ind_data
   );
endinterface
`default_nettype wire

// ==== hdl/icp_device.sv ====
// Interconnect port end: services requests, queues characters to the link
`timescale 1ns/1ns
`default_nettype none
module icp_device (
   input  wire logic              i_mclk,
   input  wire logic              i_rst_n,
   svc_if.dev                     svc,
   output logic                   o_tx_valid,
   input  wire logic              i_tx_ready,
   output logic [7:0]             o_tx_data,
   input  wire logic              i_rx_valid,
   output logic                   o_rx_ready,
   input  wire logic [7:0]        i_rx_data,
   input  wire logic              i_far_reset,
   output logic                   o_link_reset
);
   import icp_pkg::*;

   typedef struct packed {
      logic                 rdy;
      logic                 resp_v;
      resp_t                resp_code;
      logic [3:0]           resp_conn;
      logic                 ind_v;
      ind_t                 ind_kind;
      logic [3:0]           ind_conn;
      logic [1:0]           ind_buf;
      logic [2:0]           ind_cnt;
      logic [31:0]          ind_data;
      logic                 linked;
      logic                 closing;
      logic [3:0]           conn;
      logic                 conn_pend;
      logic                 rcv_pend;
      logic [1:0]           rcv_buf;
      logic [2:0]           rcv_max;
      logic [15:0][7:0]     txq;
      logic [3:0]           tx_wr;
      logic [3:0]           tx_rd;
      logic [4:0]           tx_cnt;
      logic [1:0][7:0]      sk;
      logic [1:0]           sk_cnt;
      logic                 tx_v;
      logic [7:0][7:0]      rxq;
      logic [2:0]           rx_wr;
      logic [2:0]           rx_rd;
      logic [3:0]           rx_cnt;
      logic                 rx_rdy;
      logic                 rs1;
      logic                 rs2;
      logic                 rs3;
      logic                 link_rst;
   } dev_state_t;

   dev_state_t r_reg;
   dev_state_t r_next;

   function automatic logic [2:0] min_cnt(input logic [3:0] a,
                                          input logic [2:0] b);
      min_cnt = (a < {1'b0, b}) ? a[2:0] : b;
   endfunction

   function automatic logic conn_ok(input dev_state_t s,
                                    input logic [3:0] c);
      conn_ok = s.linked && (s.conn == c);
   endfunction

   function automatic logic buf_ok(input logic [1:0] b);
      buf_ok = (b < NUM_BUF);
   endfunction

   always_comb begin
      logic [2:0] take;
      logic       far_ev;
      take = '0;
      far_ev = r_reg.rs2 && !r_reg.rs3;
      r_next = r_reg;
      r_next.resp_v = 1'b0;
      r_next.ind_v = 1'b0;
      r_next.link_rst = 1'b0;
      r_next.rdy = 1'b1;
      r_next.rs1 = i_far_reset;
      r_next.rs2 = r_reg.rs1;
      r_next.rs3 = r_reg.rs2;

      // Two-entry buffer toward the link: a stall here loses nothing
      if (r_reg.tx_v && i_tx_ready) begin
         r_next.sk[0] = r_reg.sk[1];
         r_next.sk_cnt = r_reg.sk_cnt - 2'h1;
      end
      if (r_next.sk_cnt != 2'h2 && r_reg.tx_cnt != 5'h0) begin
         r_next.sk[r_next.sk_cnt[0]] = r_reg.txq[r_reg.tx_rd];
         r_next.sk_cnt = r_next.sk_cnt + 2'h1;
         r_next.tx_rd = r_reg.tx_rd + 4'h1;
         r_next.tx_cnt = r_reg.tx_cnt - 5'h1;
      end

      // Characters arriving after close are dropped, which is allowed
      if (i_rx_valid && r_reg.rx_rdy && r_reg.linked && !r_reg.closing) begin
         r_next.rxq[r_reg.rx_wr] = i_rx_data;
         r_next.rx_wr = r_reg.rx_wr + 3'h1;
         r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
      end

      // One indication per cycle; a far reset goes first and drops the pending ones, which otherwise wait their turn
      if (far_ev) begin
         r_next.ind_v = 1'b1;
         r_next.ind_kind = ind_reset_rcvd;
         r_next.ind_conn = r_reg.conn;
         r_next.linked = 1'b0;
         r_next.closing = 1'b0;
         r_next.conn_pend = 1'b0;
         r_next.rcv_pend = 1'b0;
         r_next.tx_cnt = '0;
         r_next.tx_rd = '0;
         r_next.tx_wr = '0;
         r_next.sk_cnt = '0;
         r_next.rx_cnt = '0;
         r_next.rx_rd = '0;
         r_next.rx_wr = '0;
      end else if (r_reg.conn_pend) begin
         r_next.ind_v = 1'b1;
         r_next.ind_kind = ind_connected;
         r_next.ind_conn = r_reg.conn;
         r_next.conn_pend = 1'b0;
      end else if (r_reg.linked && r_reg.rcv_pend && r_reg.rx_cnt != 4'h0) begin
         take = min_cnt(r_reg.rx_cnt, r_reg.rcv_max);
         r_next.ind_v = 1'b1;
         r_next.ind_kind = ind_received;
         r_next.ind_conn = r_reg.conn;
         r_next.ind_buf = r_reg.rcv_buf;
         r_next.ind_cnt = take;
         r_next.ind_data = '0;
         for (int i = 0; i < SEND_MAX; i++) begin
            if (3'(i) < take) begin
               r_next.ind_data[i*CHAR_W +: CHAR_W] =
                  r_reg.rxq[3'(r_reg.rx_rd + 3'(i))];
            end
         end
         r_next.rx_rd = r_reg.rx_rd + take;
         r_next.rx_cnt = r_next.rx_cnt - {1'b0, take};
         r_next.rcv_pend = 1'b0;
      end else if (r_reg.closing && r_reg.tx_cnt == 5'h0 &&
                   r_reg.sk_cnt == 2'h0 && r_reg.rx_cnt == 4'h0) begin
         r_next.ind_v = 1'b1;
         r_next.ind_kind = ind_closed;
         r_next.ind_conn = r_reg.conn;
         r_next.linked = 1'b0;
         r_next.closing = 1'b0;
         r_next.rcv_pend = 1'b0;
      end

      // Each accepted request gets one response the next cycle
      if (svc.req_valid && r_reg.rdy) begin
         r_next.rdy = 1'b0;
         r_next.resp_v = 1'b1;
         r_next.resp_code = good_resp;
         r_next.resp_conn = svc.req_conn;
         case (svc.req_op)
            op_listen, op_connect: begin
               if (svc.req_port != LOCAL_PORT) begin
                  r_next.resp_code = inv_port_resp;
               end else if (r_next.linked || r_next.conn_pend) begin
                  r_next.resp_code = port_in_use_resp;
               end else begin
                  r_next.linked = 1'b1;
                  r_next.conn = r_reg.conn + 4'h1;
                  r_next.resp_conn = r_reg.conn + 4'h1;
                  r_next.conn_pend = 1'b1;
                  r_next.rcv_pend = 1'b0;
               end
            end
            op_send: begin
               if (!conn_ok(r_next, svc.req_conn) || r_next.closing) begin
                  r_next.resp_code = inv_conn_resp;
               end else if (!buf_ok(svc.req_buf) || svc.req_len == 3'h0 ||
                            svc.req_len > 3'(SEND_MAX)) begin
                  r_next.resp_code = inv_buf_resp;
               end else if (r_next.tx_cnt + 5'(svc.req_len) >
                            5'(TXQ_DEPTH)) begin
                  r_next.resp_code = no_room_resp;
               end else begin
                  // Good means queued, not yet on the wire
                  for (int i = 0; i < SEND_MAX; i++) begin
                     if (3'(i) < svc.req_len) begin
                        r_next.txq[4'(r_reg.tx_wr + 4'(i))] =
                           svc.req_data[i*CHAR_W +: CHAR_W];
                     end
                  end
                  r_next.tx_wr = r_reg.tx_wr + 4'(svc.req_len);
                  r_next.tx_cnt = r_next.tx_cnt + 5'(svc.req_len);
               end
            end
            op_receive: begin
               if (!conn_ok(r_next, svc.req_conn)) begin
                  r_next.resp_code = inv_conn_resp;
               end else if (!buf_ok(svc.req_buf) || svc.req_len == 3'h0) begin
                  r_next.resp_code = inv_buf_resp;
               end else if (r_next.rcv_pend) begin
                  r_next.resp_code = rcv_pending_resp;
               end else begin
                  r_next.rcv_pend = 1'b1;
                  r_next.rcv_buf = svc.req_buf;
                  r_next.rcv_max = (svc.req_len > 3'(SEND_MAX)) ?
                                   3'(SEND_MAX) : svc.req_len;
               end
            end
            op_close: begin
               if (!conn_ok(r_next, svc.req_conn) || r_next.closing) begin
                  r_next.resp_code = inv_conn_resp;
               end else begin
                  r_next.closing = 1'b1;
               end
            end
            op_reset: begin
               if (svc.req_port != LOCAL_PORT) begin
                  r_next.resp_code = inv_port_resp;
               end else begin
                  // Local flush; the far drive learns of it by the pulse
                  r_next.link_rst = 1'b1;
                  r_next.linked = 1'b0;
                  r_next.closing = 1'b0;
                  r_next.conn_pend = 1'b0;
                  r_next.rcv_pend = 1'b0;
                  r_next.tx_cnt = '0;
                  r_next.tx_rd = '0;
                  r_next.tx_wr = '0;
                  r_next.sk_cnt = '0;
                  r_next.rx_cnt = '0;
                  r_next.rx_rd = '0;
                  r_next.rx_wr = '0;
               end
            end
            default: r_next.resp_code = inv_conn_resp;
         endcase
      end

      r_next.tx_v = (r_next.sk_cnt != 2'h0);
      r_next.rx_rdy = !(r_next.linked && !r_next.closing) ||
                      (r_next.rx_cnt < 4'(RXQ_DEPTH));
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign svc.req_ready  = r_reg.rdy;
   assign svc.resp_valid = r_reg.resp_v;
   assign svc.resp_code  = r_reg.resp_code;
   assign svc.resp_conn  = r_reg.resp_conn;
   assign svc.ind_valid  = r_reg.ind_v;
   assign svc.ind_kind   = r_reg.ind_kind;
   assign svc.ind_conn   = r_reg.ind_conn;
   assign svc.ind_port   = LOCAL_PORT;
   assign svc.ind_buf    = r_reg.ind_buf;
   assign svc.ind_count  = r_reg.ind_cnt;
   assign svc.ind_data   = r_reg.ind_data;
   assign o_tx_valid     = r_reg.tx_v;
   assign o_tx_data      = r_reg.sk[0];
   assign o_rx_ready     = r_reg.rx_rdy;
   assign o_link_reset   = r_reg.link_rst;
endmodule // icp_device
`default_nettype wire

// ==== hdl/xport_end.sv ====
// Transport port end: issues service requests, returns answers to its user; a drive's local reset answer overwrites a device answer of the same cycle
`timescale 1ns/1ns
`default_nettype none
module xport_end #(
   parameter bit IS_AUTOMATION = 1'b1
) (
   input  wire logic              i_mclk,
   input  wire logic              i_rst_n,
   svc_if.xport                   svc,
   input  wire logic              i_cmd_valid,
   output logic                   o_cmd_ready,
   input  wire icp_pkg::op_t      i_cmd_op,
   input  wire logic [1:0]        i_cmd_port,
   input  wire logic [3:0]        i_cmd_conn,
   input  wire logic [1:0]        i_cmd_buf,
   input  wire logic [2:0]        i_cmd_len,
   input  wire logic [31:0]       i_cmd_data,
   output logic                   o_rsp_valid,
   output icp_pkg::resp_t         o_rsp_code,
   output logic [3:0]             o_rsp_conn,
   output logic                   o_ind_valid,
   output icp_pkg::ind_t          o_ind_kind,
   output logic [3:0]             o_ind_conn,
   output logic [1:0]             o_ind_port,
   output logic [1:0]             o_ind_buf,
   output logic [2:0]             o_ind_count,
   output logic [31:0]            o_ind_data,
   output logic                   o_close_event,
   output logic [3:0]             o_conn
);
   import icp_pkg::*;

   typedef struct packed {
      logic        cmd_rdy;
      logic        busy;
      op_t         op;
      logic [1:0]  port;
      logic [3:0]  conn;
      logic [1:0]  bufn;
      logic [2:0]  len;
      logic [31:0] data;
      logic        rsp_v;
      resp_t       rsp_code;
      logic [3:0]  rsp_conn;
      logic        ind_v;
      ind_t        ind_kind;
      logic [3:0]  ind_conn;
      logic [1:0]  ind_port;
      logic [1:0]  ind_buf;
      logic [2:0]  ind_cnt;
      logic [31:0] ind_data;
      logic        close_ev;
      logic [3:0]  cur_conn;
   } xp_state_t;

   xp_state_t r_reg;
   xp_state_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.rsp_v = 1'b0;
      r_next.ind_v = 1'b0;
      r_next.close_ev = 1'b0;
      if (r_reg.busy && svc.req_ready) begin
         r_next.busy = 1'b0;
      end
      if (svc.resp_valid) begin
         r_next.rsp_v = 1'b1;
         r_next.rsp_code = svc.resp_code;
         r_next.rsp_conn = svc.resp_conn;
      end
      if (i_cmd_valid && r_reg.cmd_rdy) begin
         if (i_cmd_op == op_reset && !IS_AUTOMATION) begin
            // A drive never resets its partner; answered here instead
            r_next.rsp_v = 1'b1;
            r_next.rsp_code = inv_port_resp;
            r_next.rsp_conn = i_cmd_conn;
         end else begin
            r_next.busy = 1'b1;
            r_next.op = i_cmd_op;
            r_next.port = i_cmd_port;
            r_next.conn = i_cmd_conn;
            r_next.bufn = i_cmd_buf;
            r_next.len = i_cmd_len;
            r_next.data = i_cmd_data;
         end
      end
      if (svc.ind_valid) begin
         r_next.ind_v = 1'b1;
         r_next.ind_kind = svc.ind_kind;
         r_next.ind_conn = svc.ind_conn;
         r_next.ind_port = svc.ind_port;
         r_next.ind_buf = svc.ind_buf;
         r_next.ind_cnt = svc.ind_count;
         r_next.ind_data = svc.ind_data;
         if (svc.ind_kind == ind_connected) begin
            r_next.cur_conn = svc.ind_conn;
         end
         if (svc.ind_kind == ind_closed) begin
            r_next.close_ev = 1'b1;
         end
      end
      // Held arguments stay stable until the device takes them
      r_next.cmd_rdy = !r_next.busy && !r_next.rsp_v;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign svc.req_valid = r_reg.busy;
   assign svc.req_op    = r_reg.op;
   assign svc.req_port  = r_reg.port;
   assign svc.req_conn  = r_reg.conn;
   assign svc.req_buf   = r_reg.bufn;
   assign svc.req_len   = r_reg.len;
   assign svc.req_data  = r_reg.data;
   assign o_cmd_ready   = r_reg.cmd_rdy;
   assign o_rsp_valid   = r_reg.rsp_v;
   assign o_rsp_code    = r_reg.rsp_code;
   assign o_rsp_conn    = r_reg.rsp_conn;
   assign o_ind_valid   = r_reg.ind_v;
   assign o_ind_kind    = r_reg.ind_kind;
   assign o_ind_conn    = r_reg.ind_conn;
   assign o_ind_port    = r_reg.ind_port;
   assign o_ind_buf     = r_reg.ind_buf;
   assign o_ind_count   = r_reg.ind_cnt;
   assign o_ind_data    = r_reg.ind_data;
   assign o_close_event = r_reg.close_ev;
   assign o_conn        = r_reg.cur_conn;
endmodule // xport_end
`default_nettype wire

// ==== verification/icp_monitor.sv ====
// Checker of the service channel between transport end and device end
`timescale 1ns/1ns
`default_nettype none
module icp_monitor (
   input wire logic           i_mclk,
   input wire logic           i_rst_n,
   input wire logic           req_valid,
   input wire logic           req_ready,
   input wire icp_pkg::op_t   req_op,
   input wire logic [1:0]     req_port,
   input wire logic [1:0]     req_buf,
   input wire logic [2:0]     req_len,
   input wire logic           resp_valid,
   input wire icp_pkg::resp_t resp_code,
   input wire logic           ind_valid,
   input wire icp_pkg::ind_t  ind_kind,
   input wire logic [2:0]     ind_count
);
   import icp_pkg::*;
   logic       take, seen_reg, shut_reg, closing_reg, pend_reg, good;
   op_t        op_reg;
   logic [2:0] len_reg, max_reg;
   assign take = req_valid && req_ready;
   assign good = resp_valid && resp_code == good_resp;
   // Shadow state only; no checks depend on hidden device counters
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         seen_reg    <= 1'b0;
         shut_reg    <= 1'b0;
         closing_reg <= 1'b0;
         pend_reg    <= 1'b0;
         op_reg      <= op_listen;
         len_reg     <= 3'h0;
         max_reg     <= 3'h0;
      end else begin
         if (take) begin
            op_reg  <= req_op;
            len_reg <= req_len;
         end
         if (take && req_op inside {op_listen, op_connect}) seen_reg <= 1'b1;
         if (ind_valid) pend_reg <= 1'b0;
         if (good && op_reg == op_reset) pend_reg <= 1'b0;
         if (good && op_reg == op_receive) begin
            pend_reg <= 1'b1;
            max_reg  <= (len_reg > 3'h4) ? 3'h4 : len_reg;
         end
         if (good && op_reg == op_close) closing_reg <= 1'b1;
         if (ind_valid && ind_kind == ind_closed) shut_reg <= 1'b1;
         if (ind_valid && ind_kind == ind_connected) begin
            shut_reg    <= 1'b0;
            closing_reg <= 1'b0;
         end
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   a_resp_next: assert property (take |=> resp_valid)
      else $error("no response after request");
   a_resp_pulse: assert property (resp_valid |-> !req_ready ##1 !resp_valid)
      else $error("response not a single pulse");
   a_bad_port: assert property (take && req_port != LOCAL_PORT &&
      req_op inside {op_listen, op_connect, op_reset}
      |=> resp_code == inv_port_resp) else $error("bad port accepted");
   a_bad_buf: assert property (take && req_op inside {op_send, op_receive}
      && (req_buf == NUM_BUF || req_len == 3'h0)
      |=> resp_code inside {inv_conn_resp, inv_buf_resp})
      else $error("bad buffer accepted");
   a_conn_cause: assert property (ind_valid && ind_kind == ind_connected
      |-> seen_reg) else $error("connected without request");
   a_rcv_max: assert property (ind_valid && ind_kind == ind_received
      |-> ind_count != 3'h0 && ind_count <= max_reg)
      else $error("received count out of range");
   a_rcv_closed: assert property (ind_valid && ind_kind == ind_received
      |-> !shut_reg) else $error("received after closed");
   a_rcv_pend: assert property (take && req_op == op_receive && pend_reg
      && !ind_valid && req_buf != NUM_BUF && req_len != 3'h0
      |=> resp_code inside {inv_conn_resp, rcv_pending_resp})
      else $error("second receive accepted");
   a_send_closed: assert property (take && req_op == op_send &&
      closing_reg |=> resp_code == inv_conn_resp)
      else $error("send after close accepted");
   c_received: cover property (ind_valid && ind_kind == ind_received);
   c_closed: cover property (ind_valid && ind_kind == ind_closed);
   c_no_room: cover property (resp_valid && resp_code == no_room_resp);
endmodule // icp_monitor
`default_nettype wire

// ==== verification/interconnect_port_services_bench.sv ====
// Self-checking bench: both ends joined, device link looped back
`timescale 1ns/1ns
`default_nettype none
module interconnect_port_services_bench;
   import icp_pkg::*;
   typedef struct packed {resp_t code; logic [3:0] conn;} rnote_t;
   typedef struct packed {ind_t kind; logic [3:0] conn;} inote_t;
   logic        mclk, rst_n, cv, cr, go, rbit, far, lrst;
   logic        tx_v, tx_r, rx_r, rv, iv, ce;
   op_t         op;
   op_t         ops[3];
   logic [1:0]  port, bsel, ip, ib, rbuf;
   logic [3:0]  conn, rcn, icn, oc;
   logic [2:0]  len, icnt, rmax;
   logic [31:0] data, idat;
   logic [7:0]  tx_d;
   logic [15:0] seed = 16'hdd30;
   resp_t       rc;
   ind_t        ik;
   rnote_t      rq[$];
   inote_t      iq[$];
   logic [7:0]  txq[$];
   logic [7:0]  rxq[$];
   int          fail_count, check_count, rx_got, nlrst, k, n, m;
   svc_if svc_if_i ();
   // Loopback: the link stalls at random and whenever receive is full
   assign tx_r = go & rbit & rx_r;
   icp_device icp_device_i (.i_mclk(mclk), .i_rst_n(rst_n), .svc(svc_if_i),
      .o_tx_valid(tx_v), .i_tx_ready(tx_r), .o_tx_data(tx_d),
      .i_rx_valid(tx_v & tx_r), .o_rx_ready(rx_r), .i_rx_data(tx_d),
      .i_far_reset(far), .o_link_reset(lrst));
   xport_end #(.IS_AUTOMATION(1'b1)) xport_end_i (.i_mclk(mclk),
      .i_rst_n(rst_n), .svc(svc_if_i), .i_cmd_valid(cv), .o_cmd_ready(cr),
      .i_cmd_op(op), .i_cmd_port(port), .i_cmd_conn(conn), .i_cmd_buf(bsel),
      .i_cmd_len(len), .i_cmd_data(data), .o_rsp_valid(rv),
      .o_rsp_code(rc), .o_rsp_conn(rcn), .o_ind_valid(iv), .o_ind_kind(ik),
      .o_ind_conn(icn), .o_ind_port(ip), .o_ind_buf(ib), .o_ind_count(icnt),
      .o_ind_data(idat), .o_close_event(ce), .o_conn(oc));
   icp_monitor icp_monitor_i (.i_mclk(mclk), .i_rst_n(rst_n),
      .req_valid(svc_if_i.req_valid), .req_ready(svc_if_i.req_ready),
      .req_op(svc_if_i.req_op), .req_port(svc_if_i.req_port),
      .req_buf(svc_if_i.req_buf), .req_len(svc_if_i.req_len),
      .resp_valid(svc_if_i.resp_valid), .resp_code(svc_if_i.resp_code),
      .ind_valid(svc_if_i.ind_valid), .ind_kind(svc_if_i.ind_kind),
      .ind_count(svc_if_i.ind_count));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0);
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("ERROR at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic cmd(input op_t o, input logic [1:0] p, input logic [3:0] c,
      input logic [1:0] b, input logic [2:0] l, input resp_t e,
      input logic [3:0] en);
      int w;
      @(posedge mclk);
      #1;
      cv = 1'b1;
      op = o;
      {port, conn, bsel, len} = {p, c, b, l};
      rq.push_back('{e, en});
      w = 0;
      do begin
         @(posedge mclk);
         w++;
      end while (cr !== 1'b1 && w < 50);
      #1;
      cv = 1'b0;
      // Overwrite the source at once: queued characters must not follow
      data = {lfsr(data[31:16]), lfsr(data[15:0])};
      w = 0;
      while (rq.size() != 0 && w < 50) begin
         @(posedge mclk);
         w++;
      end
      chk(rq.size(), 0);
      #1;
   endtask
   task automatic send(input logic [2:0] l, input resp_t e,
      input logic [3:0] c);
      if (e == good_resp)
         for (int i = 0; i < l; i++) txq.push_back(data[8*i+:8]);
      cmd(op_send, 2'h0, c, 2'h0, l, e, c);
   endtask
   task automatic settle;
      int w;
      w = 0;
      while (iq.size() != 0 && w < 400) begin
         @(posedge mclk);
         w++;
      end
      chk(iq.size(), 0);
      #1;
   endtask
   task summarize;
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      #1;
      seed = lfsr(seed);
      rbit = seed[0] | seed[3];
   end
   always @(posedge mclk) begin
      rnote_t r;
      inote_t in;
      logic [7:0] e;
      if (rv === 1'b1) begin
         r = rq.pop_front();
         chk(rc, r.code);
         chk(rcn, r.conn);
      end
      if (iv === 1'b1) begin
         chk(ce, ik == ind_closed);
         if (ik == ind_received) begin
            chk(ib, rbuf);
            chk(icnt >= 3'h1 && icnt <= rmax, 1);
            for (int i = 0; i < icnt; i++)
               chk(idat[8*i+:8], rxq.pop_front());
            rx_got += icnt;
         end else if (iq.size() == 0) begin
            chk(ik, 4'hf);
         end else begin
            in = iq.pop_front();
            chk(ik, in.kind);
            chk(ik == ind_reset_rcvd ? 4'(ip) : icn, in.conn);
            if (ik == ind_closed) chk(txq.size(), 0);
         end
      end
      if (tx_v === 1'b1 && tx_r === 1'b1) begin
         e = txq.pop_front();
         chk(tx_d, e);
         rxq.push_back(e);
      end
      if (lrst === 1'b1) nlrst++;
   end
   initial begin
      #200000;
      fail_count++;
      summarize;
   end
   initial begin
      {rst_n, cv, go, far} = 4'h0;
      {port, conn, bsel, len} = 11'h0;
      op = op_listen;
      data = {seed, seed};
      {fail_count, check_count, rx_got, nlrst, n} = 160'h0;
      repeat (5) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      ops = '{op_listen, op_connect, op_reset};
      for (int p = 1; p < 4; p++)
         for (int i = 0; i < 3; i++)
            cmd(ops[i], p[1:0], 4'h0, 2'h0, 3'h1, inv_port_resp, 4'h0);
      ops = '{op_send, op_receive, op_close};
      for (int i = 0; i < 3; i++)
         cmd(ops[i], 2'h0, 4'h1, 2'h0, 3'h1, inv_conn_resp, 4'h1);
      iq.push_back('{ind_connected, 4'h1});
      cmd(op_listen, 2'h0, 4'h0, 2'h0, 3'h0, good_resp, 4'h1);
      settle;
      ops = '{op_listen, op_connect, op_reset};
      for (int i = 0; i < 2; i++)
         cmd(ops[i], 2'h0, 4'h0, 2'h0, 3'h0, port_in_use_resp, 4'h0);
      cmd(op_send, 2'h0, 4'h1, 2'h3, 3'h1, inv_buf_resp, 4'h1);
      cmd(op_send, 2'h0, 4'h1, 2'h0, 3'h0, inv_buf_resp, 4'h1);
      cmd(op_receive, 2'h0, 4'h1, 2'h3, 3'h2, inv_buf_resp, 4'h1);
      cmd(op_send, 2'h0, 4'h2, 2'h0, 3'h1, inv_conn_resp, 4'h2);
      // Link held off: four full sends fit, the fifth has no room
      repeat (4) send(3'h4, good_resp, 4'h1);
      send(3'h4, no_room_resp, 4'h1);
      rbuf = 2'h2;
      rmax = 3'h4;
      cmd(op_receive, 2'h0, 4'h1, 2'h2, 3'h7, good_resp, 4'h1);
      cmd(op_receive, 2'h0, 4'h1, 2'h1, 3'h3, rcv_pending_resp, 4'h1);
      go = 1'b1;
      for (k = 0; k < 40 && rx_got < 16; k++) begin
         m = 0;
         while (rx_got == n && m < 300) begin
            @(posedge mclk);
            m++;
         end
         if (rx_got < 16) begin
            rbuf = 2'(k % 3);
            rmax = k[1:0] + 3'h1;
            n = rx_got;
            cmd(op_receive, 2'h0, 4'h1, rbuf, rmax, good_resp, 4'h1);
         end
      end
      chk(rx_got, 16);
      #1;
      go = 1'b0;
      send(3'h2, good_resp, 4'h1);
      iq.push_back('{ind_closed, 4'h1});
      cmd(op_close, 2'h0, 4'h1, 2'h0, 3'h0, good_resp, 4'h1);
      cmd(op_send, 2'h0, 4'h1, 2'h0, 3'h1, inv_conn_resp, 4'h1);
      cmd(op_close, 2'h0, 4'h1, 2'h0, 3'h0, inv_conn_resp, 4'h1);
      go = 1'b1;
      settle;
      rxq.delete();
      iq.push_back('{ind_connected, 4'h2});
      cmd(op_listen, 2'h0, 4'h0, 2'h0, 3'h0, good_resp, 4'h2);
      settle;
      chk(oc, 4'h2);
      iq.push_back('{ind_reset_rcvd, 4'h0});
      far = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      far = 1'b0;
      settle;
      cmd(op_send, 2'h0, 4'h2, 2'h0, 3'h1, inv_conn_resp, 4'h2);
      cmd(op_reset, 2'h0, 4'h0, 2'h0, 3'h0, good_resp, 4'h0);
      repeat (4) @(posedge mclk);
      chk(nlrst, 1);
      summarize;
   end
endmodule // interconnect_port_services_bench
`default_nettype wire
